//--- core/sfc_pkg.sv
// Purpose: Shared constants and types of the serial frame-format port
// Assumes: 32-bit plain register port, 50 MHz system clock
// Notes: Offsets are byte addresses of aligned words

package sfc_pkg;

    // ****************************************
    // Sizes and timing
    // ****************************************
    localparam int DATA_W = 8; // Bits per frame
    localparam int FIFO_DEPTH = 8; // Transmit buffer words
    localparam int CLK_PERIOD_NS = 20; // System clock period
    localparam int SCK_PERIOD_NS = 160; // Serial clock period in master mode
    // Half serial period in system cycles, rounded up
    localparam int SCK_HALF_CYC = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_PORT_CONF = 8'h00; // serial_port_configuration
    localparam logic [7:0] OFS_TIMING_GAP = 8'h04; // timing_gap_reg
    localparam logic [7:0] OFS_STATUS = 8'h08; // Status flags
    localparam logic [7:0] OFS_TX_WORD = 8'h0c; // tx_word_with_ctrl_reg data
    localparam logic [7:0] OFS_RX_WORD = 8'h10; // rx_word_reg

    // Configuration field positions
    localparam int CF_ENABLE = 0;
    localparam int CF_MASTER = 2;
    localparam int CF_LOW_BIT_FIRST = 3;
    localparam int CF_PHASE = 4;
    localparam int CF_REST = 5;
    localparam int CF_LOOP = 7;
    localparam int CF_SEL_LEVEL = 8;
    localparam logic [31:0] CONF_MASK = 32'h0000_01bd; // Implemented bits
    localparam logic [31:0] CONF_RESET = 32'h0000_0000;

    // Timing gap field positions
    localparam int GF_PRE = 0;
    localparam int GF_POST = 4;
    localparam int GF_FRAME = 8;
    localparam int GF_XFER = 12;
    localparam logic [15:0] GAP_RESET = 16'h0000;

    // Status bit positions
    localparam int SF_RX_VALID = 0;
    localparam int SF_TX_READY = 1;
    localparam int SF_BUSY = 2;
    localparam int SF_SEL_SEEN = 3;

    // Master sequencer states
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_PRE = 3'h1,
        M_SHIFT = 3'h2,
        M_FGAP = 3'h3,
        M_POST = 3'h4,
        M_XGAP = 3'h5
    } sfc_mstate_e;

endpackage

//--- core/sfc_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clock
// Notes: Only the second stage is visible outside

`timescale 1ns/1ns
`default_nettype none

module sfc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // ****************************************
    // Stages
    // ****************************************
    logic [WIDTH-1:0] meta_q; // First stage, read only by second
    logic [WIDTH-1:0] sync_q; // Second stage

    // Shift pins through both stages
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- core/sfc_fifo.sv
// Purpose: Transmit word buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Push when full and pop when empty are ignored

`timescale 1ns/1ns
`default_nettype none

module sfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);

    // ****************************************
    // Storage and pointers
    // ****************************************
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // Word storage
    logic [AW:0] wp_q, wp_d; // Write pointer with wrap bit
    logic [AW:0] rp_q, rp_d; // Read pointer with wrap bit
    logic do_push, do_pop;

    assign o_valid = (wp_q != rp_q);
    assign o_ready = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
    assign o_data = mem_q[rp_q[AW-1:0]];

    // Pointer advance
    always_comb begin
        do_push = i_valid && o_ready;
        do_pop = i_ready && o_valid;
        wp_d = do_push ? wp_q + 1'b1 : wp_q;
        rp_d = do_pop ? rp_q + 1'b1 : rp_q;
    end

    // Pointers and storage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (do_push) begin
            mem_q[wp_q[AW-1:0]] <= i_data;
        end
    end

endmodule

`default_nettype wire

//--- core/sfc_port.sv
// Purpose: Serial peripheral port with configurable frame format
// Assumes: Plain register port, pins sampled through synchronisers
// Notes: Master sequencing counts in half serial periods
// Functional notes
// - Bit-order set shifts least significant first
// - Phase zero samples first edge, changes next
// - Phase one changes first edge, samples next
// - Polarity field sets clock rest level
// - Master loopback feeds transmit into receive
// - Select polarity zero: active-low, no inversion
// - Select polarity one: active-high, inverted
// - Delays only in master, serial periods
// - One period from select to first edge

`timescale 1ns/1ns
`default_nettype none

module sfc_port #(
    parameter int DATA_W = sfc_pkg::DATA_W,
    parameter int FIFO_DEPTH = sfc_pkg::FIFO_DEPTH,
    parameter int HALF_CYC = sfc_pkg::SCK_HALF_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_sck,
    output logic o_sck,
    output logic o_sck_oe,
    input wire logic i_mosi,
    output logic o_mosi,
    output logic o_mosi_oe,
    input wire logic i_miso,
    output logic o_miso,
    output logic o_miso_oe,
    input wire logic i_ssel,
    output logic o_ssel,
    output logic o_ssel_oe
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int ECW = $clog2(2 * DATA_W); // Edge counter width
    localparam int BCW = $clog2(DATA_W); // Bit counter width
    localparam logic [ECW-1:0] LAST_EDGE = ECW'(2 * DATA_W - 1);
    localparam logic [BCW-1:0] LAST_BIT = BCW'(DATA_W - 1);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    logic [31:0] conf_q, conf_d; // serial_port_configuration
    logic [15:0] gap_q, gap_d; // timing_gap_reg
    logic [DATA_W-1:0] rxw_q, rxw_d; // rx_word_reg contents
    logic rxv_q, rxv_d; // Received word waiting
    logic [31:0] rdata_q, rdata_d; // Read answer
    sfc_pkg::sfc_mstate_e m_state_q, m_state_d; // Master sequencer
    logic [7:0] div_q, div_d; // Half-period divider
    logic [5:0] cnt_q, cnt_d; // Delay count in half periods
    logic [ECW-1:0] edge_q, edge_d; // Master edge index
    logic [BCW-1:0] bit_q, bit_d; // Sampled bit index
    logic [DATA_W-1:0] sh_q, sh_d; // Transmit shifter
    logic [DATA_W-1:0] rx_q, rx_d; // Receive shifter
    logic [DATA_W-1:0] txw_q, txw_d; // Word last loaded
    logic out_q, out_d; // Serial data out bit
    logic fresh_q, fresh_d; // Skip next change event
    logic sck_q, sck_d; // Master clock level
    logic sel_q, sel_d; // Select field, one is idle
    logic pin_sel_q; // Select pin level
    logic m_oe_q, s_oe_q; // Output enables
    logic sck_p_q; // Previous synced serial clock
    logic sl_act_q; // Slave select seen last cycle
    logic [8:0] pre_cyc_q; // Cycles spent in the M_PRE wait

    logic [3:0] pin_s; // Synced sck, mosi, miso, ssel
    logic en, is_master, is_slave, low_bit_first, phase, rest, loop_on, sel_pol;
    logic tick, wait_done, lead, trail, sample, change, load, mid_load;
    logic rx_push, rx_bit, sl_active, sl_start, sck_edge, sel_field_in;
    logic fifo_ready, fifo_valid, fifo_pop, tx_write;
    logic [DATA_W-1:0] fifo_data, sh_next, word;

    // Field decode
    assign en = conf_q[sfc_pkg::CF_ENABLE];
    assign is_master = en && conf_q[sfc_pkg::CF_MASTER];
    assign is_slave = en && !conf_q[sfc_pkg::CF_MASTER];
    assign low_bit_first = conf_q[sfc_pkg::CF_LOW_BIT_FIRST];
    assign phase = conf_q[sfc_pkg::CF_PHASE];
    assign rest = conf_q[sfc_pkg::CF_REST];
    assign loop_on = conf_q[sfc_pkg::CF_LOOP];
    assign sel_pol = conf_q[sfc_pkg::CF_SEL_LEVEL];
    assign tx_write = i_wr && (i_addr == sfc_pkg::OFS_TX_WORD);

    // ****************************************
    // Pin synchronisers and transmit buffer
    // ****************************************
    sfc_sync #(
        .WIDTH(4)
    ) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({i_sck, i_mosi, i_miso, i_ssel}),
        .o_sync(pin_s)
    );

    sfc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_data(i_wdata[DATA_W-1:0]),
        .i_valid(tx_write),
        .o_ready(fifo_ready),
        .o_data(fifo_data),
        .o_valid(fifo_valid),
        .i_ready(fifo_pop)
    );

    // ****************************************
    // Register file
    // ****************************************
    // Writes, reads and received-word flag
    always_comb begin
        conf_d = conf_q;
        gap_d = gap_q;
        rdata_d = 32'h0000_0000;
        rxw_d = rx_push ? rx_d : rxw_q;
        rxv_d = rxv_q;
        if (i_wr && i_addr == sfc_pkg::OFS_PORT_CONF) begin
            conf_d = i_wdata & sfc_pkg::CONF_MASK;
        end
        if (i_wr && i_addr == sfc_pkg::OFS_TIMING_GAP) begin
            gap_d = i_wdata[15:0];
        end
        if (i_rd) begin
            case (i_addr)
                sfc_pkg::OFS_PORT_CONF: rdata_d = conf_q;
                sfc_pkg::OFS_TIMING_GAP: rdata_d = {16'h0000, gap_q};
                sfc_pkg::OFS_STATUS: begin
                    rdata_d[sfc_pkg::SF_RX_VALID] = rxv_q;
                    rdata_d[sfc_pkg::SF_TX_READY] = fifo_ready;
                    rdata_d[sfc_pkg::SF_BUSY] = (m_state_q != sfc_pkg::M_IDLE);
                    rdata_d[sfc_pkg::SF_SEL_SEEN] = sel_field_in;
                end
                sfc_pkg::OFS_RX_WORD: begin
                    rdata_d = {{(32 - DATA_W){1'b0}}, rxw_q};
                    rxv_d = 1'b0;
                end
                default: rdata_d = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
        if (rx_push) begin
            rxv_d = 1'b1; // New word wins over a read clear
        end
    end

    // Register file storage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            conf_q <= sfc_pkg::CONF_RESET;
            gap_q <= sfc_pkg::GAP_RESET;
            rxw_q <= '0;
            rxv_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            conf_q <= conf_d;
            gap_q <= gap_d;
            rxw_q <= rxw_d;
            rxv_q <= rxv_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // Serial engine
    // ****************************************
    // Select field seen on pin, zero means asserted
    assign sel_field_in = pin_s[0] ^ sel_pol;
    assign sl_active = is_slave && !sel_field_in;
    assign sl_start = sl_active && !sl_act_q;
    assign sck_edge = pin_s[3] != sck_p_q;
    assign tick = (div_q == HALF_LAST);
    // Loopback takes our own data out, not the pin
    assign rx_bit = is_master ? (loop_on ? out_q : pin_s[1]) : pin_s[2];
    // Next shifter value in the chosen bit order
    assign sh_next = low_bit_first ? {1'b0, sh_q[DATA_W-1:1]} : {sh_q[DATA_W-2:0], 1'b0};

    // Sequencer, shifters and pin levels
    always_comb begin
        m_state_d = m_state_q;
        div_d = tick ? 8'h00 : div_q + 8'h01;
        cnt_d = cnt_q;
        edge_d = edge_q;
        bit_d = bit_q;
        sh_d = sh_q;
        rx_d = rx_q;
        txw_d = txw_q;
        out_d = out_q;
        fresh_d = fresh_q;
        sck_d = sck_q;
        sel_d = sel_q;
        fifo_pop = 1'b0;
        load = 1'b0;
        mid_load = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        rx_push = 1'b0;
        word = '0;
        wait_done = (cnt_q == 6'h00) || (tick && cnt_q == 6'h01);
        if (tick && cnt_q != 6'h00) begin
            cnt_d = cnt_q - 6'h01;
        end
        case (m_state_q)
            sfc_pkg::M_IDLE: begin
                sck_d = rest;
                sel_d = 1'b1;
                if (is_master && fifo_valid) begin
                    sel_d = 1'b0;
                    // Restart divider so the select-to-edge time is exact
                    div_d = 8'h00;
                    // Pre-frame gap plus one half period; first shift tick adds the other
                    cnt_d = {1'b0, gap_q[sfc_pkg::GF_PRE +: 4], 1'b0} + 6'h01;
                    load = 1'b1;
                    m_state_d = sfc_pkg::M_PRE;
                end
            end
            sfc_pkg::M_PRE: begin
                if (wait_done) begin
                    edge_d = '0;
                    m_state_d = sfc_pkg::M_SHIFT;
                end
            end
            sfc_pkg::M_SHIFT: begin
                if (tick) begin
                    sck_d = ~sck_q;
                    lead = !edge_q[0];
                    trail = edge_q[0];
                    edge_d = edge_q + 1'b1;
                    if (edge_q == LAST_EDGE) begin
                        if (fifo_valid) begin
                            cnt_d = {1'b0, gap_q[sfc_pkg::GF_FRAME +: 4], 1'b0};
                            m_state_d = sfc_pkg::M_FGAP;
                        end else begin
                            cnt_d = {1'b0, gap_q[sfc_pkg::GF_POST +: 4], 1'b0};
                            m_state_d = sfc_pkg::M_POST;
                        end
                    end
                end
            end
            sfc_pkg::M_FGAP: begin
                if (wait_done) begin
                    load = 1'b1;
                    edge_d = '0;
                    m_state_d = sfc_pkg::M_SHIFT;
                end
            end
            sfc_pkg::M_POST: begin
                if (wait_done) begin
                    sel_d = 1'b1;
                    cnt_d = {1'b0, gap_q[sfc_pkg::GF_XFER +: 4], 1'b0} + 6'h02;
                    m_state_d = sfc_pkg::M_XGAP;
                end
            end
            sfc_pkg::M_XGAP: begin
                if (wait_done) begin
                    m_state_d = sfc_pkg::M_IDLE;
                end
            end
            default: m_state_d = sfc_pkg::M_IDLE;
        endcase
        // Slave edges come from the synced pin clock
        if (sl_active) begin
            lead = sck_edge && (pin_s[3] != rest);
            trail = sck_edge && (pin_s[3] == rest);
            load = sl_start;
        end else if (is_slave) begin
            bit_d = '0;
        end
        sample = phase ? trail : lead;
        change = phase ? lead : trail;
        if (change) begin
            if (fresh_q) begin
                fresh_d = 1'b0;
            end else begin
                sh_d = sh_next;
                out_d = low_bit_first ? sh_next[0] : sh_next[DATA_W-1];
            end
        end
        if (sample) begin
            rx_d = low_bit_first ? {rx_bit, rx_q[DATA_W-1:1]} : {rx_q[DATA_W-2:0], rx_bit};
            bit_d = bit_q + 1'b1;
            if (bit_q == LAST_BIT) begin
                rx_push = 1'b1;
                bit_d = '0;
                mid_load = sl_active;
                load = load || sl_active;
            end
        end
        if (load) begin
            word = fifo_valid ? fifo_data : '0;
            fifo_pop = fifo_valid;
            sh_d = word;
            txw_d = word;
            out_d = low_bit_first ? word[0] : word[DATA_W-1];
            fresh_d = mid_load || phase;
            bit_d = '0;
        end
        // Outside master mode the sequencer and its delays stay idle
        if (!is_master) begin
            m_state_d = sfc_pkg::M_IDLE;
            sel_d = 1'b1;
            sck_d = rest;
        end
    end

    // Serial engine storage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            m_state_q <= sfc_pkg::M_IDLE;
            div_q <= 8'h00;
            cnt_q <= 6'h00;
            edge_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            rx_q <= '0;
            txw_q <= '0;
            out_q <= 1'b0;
            fresh_q <= 1'b0;
            sck_q <= 1'b0;
            sel_q <= 1'b1;
            pin_sel_q <= 1'b1;
            m_oe_q <= 1'b0;
            s_oe_q <= 1'b0;
            sck_p_q <= 1'b0;
            sl_act_q <= 1'b0;
            pre_cyc_q <= 9'h000;
        end else begin
            m_state_q <= m_state_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            edge_q <= edge_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            txw_q <= txw_d;
            out_q <= out_d;
            fresh_q <= fresh_d;
            sck_q <= sck_d;
            sel_q <= sel_d;
            pin_sel_q <= sel_d ^ sel_pol;
            m_oe_q <= is_master;
            s_oe_q <= sl_active;
            sck_p_q <= pin_s[3];
            sl_act_q <= sl_active;
            pre_cyc_q <= (m_state_q == sfc_pkg::M_PRE) ? pre_cyc_q + 9'h001 : 9'h000;
        end
    end

    // Pins and read data straight from flops
    assign o_rdata = rdata_q;
    assign o_sck = sck_q;
    assign o_sck_oe = m_oe_q;
    assign o_mosi = out_q;
    assign o_mosi_oe = m_oe_q;
    assign o_miso = out_q;
    assign o_miso_oe = s_oe_q;
    assign o_ssel = pin_sel_q;
    assign o_ssel_oe = m_oe_q;

    // ****************************************
    // Assertions
    // ****************************************
    a_lsb_first_out: assert property (@(posedge i_clock) disable iff (i_rst)
        (is_master && load && low_bit_first) |=> (out_q == txw_q[0]))
        else $error("first bit out is not the low bit");
    a_phase0_change: assert property (@(posedge i_clock) disable iff (i_rst)
        (m_state_q == sfc_pkg::M_SHIFT && $past(m_state_q) == sfc_pkg::M_SHIFT
        && !phase && $changed(out_q)) |-> $past(trail))
        else $error("phase zero data changed off a trailing edge");
    a_phase1_change: assert property (@(posedge i_clock) disable iff (i_rst)
        (m_state_q == sfc_pkg::M_SHIFT && $past(m_state_q) == sfc_pkg::M_SHIFT
        && phase && $changed(out_q)) |-> $past(lead))
        else $error("phase one data changed off a leading edge");
    a_clock_rest: assert property (@(posedge i_clock) disable iff (i_rst)
        ($past(m_state_q) == sfc_pkg::M_IDLE) |-> (sck_q == $past(rest)))
        else $error("serial clock not at rest level");
    a_loop_echo: assert property (@(posedge i_clock) disable iff (i_rst)
        (rx_push && is_master && loop_on) |-> (rx_d == txw_q))
        else $error("loopback word differs from sent word");
    a_sel_low: assert property (@(posedge i_clock) disable iff (i_rst)
        (m_state_q == sfc_pkg::M_SHIFT && !sel_pol && $stable(sel_pol)) |-> !o_ssel)
        else $error("select not low in frame");
    a_sel_high: assert property (@(posedge i_clock) disable iff (i_rst)
        (m_state_q == sfc_pkg::M_SHIFT && sel_pol && $stable(sel_pol)) |-> o_ssel)
        else $error("select not high in frame");
    a_slave_no_seq: assert property (@(posedge i_clock) disable iff (i_rst)
        !is_master |=> (m_state_q == sfc_pkg::M_IDLE))
        else $error("sequencer ran outside master mode");
    a_reset_zero: assert property (@(posedge i_clock) disable iff (i_rst)
        $past(i_rst) |-> (conf_q == 32'h0000_0000))
        else $error("format fields not zero after reset");
    a_pre_gap: assert property (@(posedge i_clock) disable iff (i_rst)
        (m_state_q == sfc_pkg::M_PRE && m_state_d == sfc_pkg::M_SHIFT)
        |-> (int'(pre_cyc_q) + 1 == (2 * int'(gap_q[3:0]) + 1) * HALF_CYC))
        else $error("first edge came too soon after select");

endmodule

`default_nettype wire

//--- tb/sfc_peer.sv
// Purpose: Serial peer on the far side of the port in master mode
// Assumes: Peer sees the pins once per system clock
// Notes: mode is {select level, bit order, rest level, phase} as {select_active_level, low_bit_first, clk_rest_level, clk_phase_sel}
`timescale 1ns/1ns
`default_nettype none
module sfc_peer (
    input wire logic i_clock,
    input wire logic i_sck,
    input wire logic i_ssel,
    input wire logic i_mosi,
    input wire logic [3:0] i_mode,
    input wire logic [7:0] i_tx,
    output logic o_miso,
    output logic [7:0] o_rx
);
    logic sck_p = 1'b0; // Last seen clock level
    logic first = 1'b1; // No leading edge seen yet
    logic junk = 1'b0; // Toggles every cycle, on the line while not selected
    logic [7:0] sh = 8'h00; // Outgoing shifter, top bit on the line
    wire logic sel = (i_ssel == i_mode[3]);
    wire logic lead = (sck_p == i_mode[1]) && (i_sck != i_mode[1]);
    wire logic trail = (sck_p != i_mode[1]) && (i_sck == i_mode[1]);
    // Released line never holds its last value
    assign o_miso = sel ? sh[7] : junk;
    // Load while idle, then shift and sample per phase
    always @(posedge i_clock) begin
        sck_p <= i_sck;
        junk <= ~junk;
        if (!sel) begin
            for (int b = 0; b < 8; b++) begin
                sh[b] <= i_mode[2] ? i_tx[7 - b] : i_tx[b];
            end
            first <= 1'b1;
        end else begin
            if (i_mode[0] ? (lead && !first) : trail) begin
                sh <= {sh[6:0], 1'b0};
            end
            if (lead) begin
                first <= 1'b0;
            end
            if (i_mode[0] ? trail : lead) begin
                o_rx <= {o_rx[6:0], i_mosi};
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/spi_frame_format_config_tb.sv
// Purpose: Self-checking bench of the serial port frame formats
// Assumes: Peer model on the data lines in master mode, bench drives slave pins
// Notes: Select pin output is fed back to the select input
`timescale 1ns/1ns
`default_nettype none
module spi_frame_format_config_tb;
    localparam int H = sfc_pkg::SCK_HALF_CYC;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_sck, o_mosi, o_ssel, miso;
    logic o_miso; // Slave data out
    logic [3:0] oe; // Enables: sck, mosi, ssel, miso
    logic s_on = 1'b0; // Bench owns the select input
    logic s_ssel = 1'b1;
    logic s_sck = 1'b0;
    logic s_mosi = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [7:0] ptx = 8'h00;
    logic [7:0] prx;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    sfc_port DUT (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sck(s_sck), .o_sck(o_sck),
        .o_sck_oe(oe[3]), .i_mosi(s_mosi), .o_mosi(o_mosi), .o_mosi_oe(oe[2]),
        .i_miso(miso), .o_miso(o_miso), .o_miso_oe(oe[0]),
        .i_ssel(s_on ? s_ssel : o_ssel), .o_ssel(o_ssel), .o_ssel_oe(oe[1]));
    sfc_peer peer (.i_clock(i_clock), .i_sck(o_sck), .i_ssel(o_ssel), .i_mosi(o_mosi),
        .i_mode(mode), .i_tx(ptx), .o_miso(miso), .o_rx(prx));
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    // Cycle ceiling against hangs
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] d;
        rd(sfc_pkg::OFS_PORT_CONF, d);
        chk("config reset", 32'h0, d);
        rd(8'h14, d);
        chk("unmapped", 32'h0, d);
        chk("oe reset", 32'h0, 32'(oe));
        $display("test reset done");
    endtask
    // One word with mode {select_active_level, low_bit_first, clk_rest_level, clk_phase_sel}, optional loopback
    task automatic t_xfer(input logic [3:0] m, input logic lp, input logic [7:0] tx,
            input logic [3:0] pre);
        logic [31:0] d;
        logic [31:0] cfg;
        logic [7:0] exp;
        int w;
        cfg = {23'h0, m[3], lp, 1'b0, m[1], m[0], m[2], 2'b10, 1'b1};
        exp = lp ? tx : (tx ^ 8'h5a);
        mode <= m;
        ptx <= lp ? ~tx : exp;
        wr(sfc_pkg::OFS_TIMING_GAP, {28'h0, pre});
        wr(sfc_pkg::OFS_PORT_CONF, cfg);
        rd(sfc_pkg::OFS_PORT_CONF, d);
        chk("config", cfg, d);
        repeat (3) @(posedge i_clock);
        chk("sck rest", 32'(m[1]), 32'(o_sck));
        chk("ssel idle", 32'(!m[3]), 32'(o_ssel));
        chk("master oe", 32'he, 32'(oe));
        wr(sfc_pkg::OFS_TX_WORD, {24'h0, tx});
        w = 0;
        while (o_ssel !== m[3] && w < 100) begin
            @(negedge i_clock);
            w++;
        end
        w = 0;
        while (o_sck === m[1] && w < 300) begin
            @(negedge i_clock);
            w++;
        end
        chk("pre gap", 32'h1, 32'(w >= (2 * pre + 1) * H && w <= (2 * pre + 2) * H + 1));
        w = 0;
        d = 32'h0;
        while (d[sfc_pkg::SF_RX_VALID] !== 1'b1 && w < 200) begin
            rd(sfc_pkg::OFS_STATUS, d);
            w++;
        end
        rd(sfc_pkg::OFS_RX_WORD, d);
        chk("rx word", {24'h0, exp}, d);
        for (int b = 0; b < 8; b++) begin
            exp[b] = m[2] ? tx[7 - b] : tx[b];
        end
        chk("peer rx", {24'h0, exp}, {24'h0, prx});
        w = 0;
        d = 32'hffff_ffff;
        while (d[sfc_pkg::SF_BUSY] !== 1'b0 && w < 200) begin
            rd(sfc_pkg::OFS_STATUS, d);
            w++;
        end
        chk("idle", 32'h0, 32'(d[sfc_pkg::SF_BUSY]));
        $display("test xfer done mode %h loop %b", m, lp);
    endtask
    // Slave frame in mode zero, bench drives the pins, all delays set
    task automatic t_slave(input logic [7:0] tx, input logic [7:0] rx);
        logic [31:0] d;
        logic [7:0] got;
        wr(sfc_pkg::OFS_TIMING_GAP, 32'h0000_ffff);
        s_on <= 1'b1;
        wr(sfc_pkg::OFS_PORT_CONF, 32'h0000_0001);
        wr(sfc_pkg::OFS_TX_WORD, {24'h0, tx});
        s_ssel <= 1'b0;
        repeat (8) @(posedge i_clock);
        chk("slave oe", 32'h1, 32'(oe));
        for (int b = 7; b >= 0; b--) begin
            s_mosi <= rx[b];
            repeat (8) @(posedge i_clock);
            got[b] = o_miso;
            s_sck <= 1'b1;
            repeat (8) @(posedge i_clock);
            s_sck <= 1'b0;
        end
        repeat (8) @(posedge i_clock);
        chk("slave out", {24'h0, tx}, {24'h0, got});
        rd(sfc_pkg::OFS_STATUS, d);
        chk("slave busy", 32'h0, 32'(d[sfc_pkg::SF_BUSY]));
        rd(sfc_pkg::OFS_RX_WORD, d);
        chk("slave rx", {24'h0, rx}, d);
        s_ssel <= 1'b1;
        $display("test slave done");
    endtask
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        for (int k = 0; k < 16; k++) begin
            t_xfer(4'(k), 1'b0, 8'h31 + 8'(k), 4'(k % 3));
        end
        t_xfer(4'h5, 1'b1, 8'hc6, 4'h1);
        t_xfer(4'ha, 1'b1, 8'h3b, 4'h0);
        t_slave(8'h96, 8'h4d);
        final_report();
    end
endmodule
`default_nettype wire
